// ### nicdf_pkg.sv
// constants, register map and timing for the dma, filter and framing block
//
// Functional notes
// - transmit length is 16 bits in two bytes
// - full programmed length sent, never truncated
// - ring first and end pages give bits 15:8
// - abort local dma when next page hits read page
// - write page restores dma pointers on errors
// - local dma address readable as two bytes
// - remote dma uses start address and count
// - low and high bytes of start and count
// - remote address steps two per word, one per byte
// - remote count drops two per word, one per byte
// - current remote address readable as two bytes
// - destination compared bytewise against station address
// - first destination bit marks multicast address
// - six crc msbs latched at last destination bit
// - hash selects one of 64 filter bits
// - transmit adds preamble, delimiter and fcs
// - receive strips preamble, keeps crc in memory
// - 62 alternating preamble bits before delimiter
// - receive aligns on two consecutive one bits
// - receive address wraps from end page to first
// - first page skips four bytes for status
// - standard 32-bit ethernet crc polynomial
package nicdf_pkg;
   // register indices on the 8-bit register port
   localparam logic [4:0] REG_TX_LEN_LO   = 5'h00;
   localparam logic [4:0] REG_TX_LEN_HI   = 5'h01;
   localparam logic [4:0] REG_TX_PAGE     = 5'h02;
   localparam logic [4:0] REG_RING_FIRST  = 5'h03;
   localparam logic [4:0] REG_RING_END    = 5'h04;
   localparam logic [4:0] REG_RING_READ   = 5'h05;
   localparam logic [4:0] REG_RING_WRITE  = 5'h06;
   localparam logic [4:0] REG_LDA_LO      = 5'h07;
   localparam logic [4:0] REG_LDA_HI      = 5'h08;
   localparam logic [4:0] REG_RSTART_LO   = 5'h09;
   localparam logic [4:0] REG_RSTART_HI   = 5'h0a;
   localparam logic [4:0] REG_RCOUNT_LO   = 5'h0b;
   localparam logic [4:0] REG_RCOUNT_HI   = 5'h0c;
   localparam logic [4:0] REG_RADDR_LO    = 5'h0d;
   localparam logic [4:0] REG_RADDR_HI    = 5'h0e;
   localparam logic [4:0] REG_CTRL        = 5'h0f;
   localparam logic [4:0] REG_STATION0    = 5'h10;
   localparam logic [4:0] REG_HASH0       = 5'h18;
   // control register bits
   localparam int CTRL_TX_GO   = 0;
   localparam int CTRL_RDMA_GO = 1;
   localparam int CTRL_WORD    = 2;
   localparam int CTRL_RX_EN   = 3;
   // crc
   localparam logic [31:0] CRC_POLY    = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT    = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hc704dd7b;
   // framing
   localparam logic [5:0] PRE_LAST     = 6'h3f;
   localparam logic [5:0] PRE_ALT_BITS = 6'h3e;
   localparam logic [5:0] FCS_LAST     = 6'h1f;
   localparam logic [5:0] DEST_LAST    = 6'h2f;
   localparam logic [7:0] STATUS_SKIP  = 8'h04;
   localparam logic [2:0] DEST_BYTES   = 3'h6;
   localparam logic [7:0] RX_STAT_OK   = 8'h01;
   localparam logic [7:0] RX_STAT_MC   = 8'h20;
   // timing
   localparam int CLK_NS = 25;
   localparam int BIT_NS = 100;
   localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : nicdf_pkg

// ### nicdf_top.sv
// dma pointers, address filter and frame encapsulation of the nic core
`timescale 1ns/10ps
`default_nettype none

module nicdf_top (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   // register port
   input  wire logic [4:0]                 reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output var  logic [7:0]                 reg_rdata,
   // local dma port to buffer memory
   output var  logic [15:0]                lmem_addr,
   output var  logic [7:0]                 lmem_wdata,
   output var  logic                       lmem_we,
   output var  logic                       lmem_re,
   input  wire logic [7:0]                 lmem_rdata,
   // remote dma steps
   output var  logic                       rdma_req,
   output var  logic [15:0]                rdma_addr,
   output var  logic                       rdma_word,
   input  wire logic                       rdma_ack,
   // serial nrz transmit
   output var  logic                       tx_bit,
   output var  logic                       tx_en,
   // serial nrz receive, from decoder pins
   input  wire logic                       rx_crs,
   input  wire logic                       rx_bit,
   input  wire logic                       rx_stb
);
   import nicdf_pkg::*;

   typedef enum logic [1:0] {T_IDLE, T_PRE, T_DATA, T_FCS} nicdf_tx_t;
   typedef enum logic [2:0] {R_IDLE, R_HUNT, R_DATA, R_HDR, R_DROP}
      nicdf_rx_t;

   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic b);
      crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h0);
   endfunction

   function automatic logic [7:0] page_next(input logic [7:0] p,
                                            input logic [7:0] first,
                                            input logic [7:0] last);
      page_next = (p + 8'h01 == last) ? first : p + 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] tx_length;
   logic [7:0]  tx_page;
   logic [7:0]  ring_first_page;
   logic [7:0]  ring_end_page;
   logic [7:0]  ring_read_page;
   logic [7:0]  ring_write_page;
   logic [15:0] remote_start;
   logic [15:0] remote_count;
   logic [7:0]  station_addr_bytes [0:5];
   logic [63:0] multicast_hash_filter;
   logic        word_mode;
   logic        rx_enable;

   logic [15:0] tx_addr;
   logic [15:0] rx_addr;
   logic [15:0] raddr;
   logic [15:0] rcnt;
   logic        rdma_busy;
   nicdf_tx_t   tx_st;
   nicdf_rx_t   rx_st;

   wire ctrl_wr   = reg_wr && reg_addr == REG_CTRL;
   wire tx_go     = ctrl_wr && reg_wdata[CTRL_TX_GO];
   wire rdma_go   = ctrl_wr && reg_wdata[CTRL_RDMA_GO];
   wire [15:0] lda = (tx_st != T_IDLE) ? tx_addr : rx_addr;
   wire [7:0] ctrl_rd = {4'h0, rx_enable, word_mode, rdma_busy,
                         tx_st != T_IDLE};
   wire hdr_done;
   wire [7:0] hdr_next_page;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_length       <= 16'h0000;
         tx_page         <= 8'h00;
         ring_first_page <= 8'h00;
         ring_end_page   <= 8'h00;
         ring_read_page  <= 8'h00;
         remote_start    <= 16'h0000;
         remote_count    <= 16'h0000;
         word_mode       <= 1'b0;
         rx_enable       <= 1'b0;
         multicast_hash_filter <= 64'h0;
         for (int i = 0; i < 6; i++) station_addr_bytes[i] <= 8'h00;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_TX_LEN_LO:  tx_length[7:0]        <= reg_wdata;
            REG_TX_LEN_HI:  tx_length[15:8]       <= reg_wdata;
            REG_TX_PAGE:    tx_page               <= reg_wdata;
            REG_RING_FIRST: ring_first_page       <= reg_wdata;
            REG_RING_END:   ring_end_page         <= reg_wdata;
            REG_RING_READ:  ring_read_page        <= reg_wdata;
            REG_RSTART_LO:  remote_start[7:0]     <= reg_wdata;
            REG_RSTART_HI:  remote_start[15:8]    <= reg_wdata;
            REG_RCOUNT_LO:  remote_count[7:0]     <= reg_wdata;
            REG_RCOUNT_HI:  remote_count[15:8]    <= reg_wdata;
            REG_CTRL: begin
               word_mode <= reg_wdata[CTRL_WORD];
               rx_enable <= reg_wdata[CTRL_RX_EN];
            end
            default: begin
               if (reg_addr[4:3] == REG_STATION0[4:3] && reg_addr[2:0] < 3'h6)
                  station_addr_bytes[reg_addr[2:0]] <= reg_wdata;
               if (reg_addr[4:3] == REG_HASH0[4:3])
                  multicast_hash_filter[{reg_addr[2:0], 3'h0} +: 8]
                     <= reg_wdata;
            end
         endcase
      end
   end

   // write page: host sets it at init, device advances after each accepted packet
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         ring_write_page <= 8'h00;
      else if (reg_wr && reg_addr == REG_RING_WRITE)
         ring_write_page <= reg_wdata;
      else if (hdr_done)
         ring_write_page <= hdr_next_page;
   end

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         REG_TX_LEN_LO:  rd_mux = tx_length[7:0];
         REG_TX_LEN_HI:  rd_mux = tx_length[15:8];
         REG_TX_PAGE:    rd_mux = tx_page;
         REG_RING_FIRST: rd_mux = ring_first_page;
         REG_RING_END:   rd_mux = ring_end_page;
         REG_RING_READ:  rd_mux = ring_read_page;
         REG_RING_WRITE: rd_mux = ring_write_page;
         REG_LDA_LO:     rd_mux = lda[7:0];
         REG_LDA_HI:     rd_mux = lda[15:8];
         REG_RSTART_LO:  rd_mux = remote_start[7:0];
         REG_RSTART_HI:  rd_mux = remote_start[15:8];
         REG_RCOUNT_LO:  rd_mux = remote_count[7:0];
         REG_RCOUNT_HI:  rd_mux = remote_count[15:8];
         REG_RADDR_LO:   rd_mux = raddr[7:0];
         REG_RADDR_HI:   rd_mux = raddr[15:8];
         REG_CTRL:       rd_mux = ctrl_rd;
         default: begin
            if (reg_addr[4:3] == REG_STATION0[4:3] && reg_addr[2:0] < 3'h6)
               rd_mux = station_addr_bytes[reg_addr[2:0]];
            else if (reg_addr[4:3] == REG_HASH0[4:3])
               rd_mux = multicast_hash_filter[{reg_addr[2:0], 3'h0} +: 8];
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // remote dma: one step per ack, word steps only while two bytes remain
   wire [15:0] rstep = (word_mode && rcnt > 16'h0001) ? 16'h0002 : 16'h0001;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         raddr     <= 16'h0000;
         rcnt      <= 16'h0000;
         rdma_busy <= 1'b0;
      end else if (rdma_go && !rdma_busy) begin
         raddr     <= remote_start;
         rcnt      <= remote_count;
         rdma_busy <= remote_count != 16'h0000;
      end else if (rdma_busy && rdma_req && rdma_ack) begin
         raddr     <= raddr + rstep;
         rcnt      <= rcnt - rstep;
         rdma_busy <= rcnt != rstep;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdma_req  <= 1'b0;
         rdma_addr <= 16'h0000;
         rdma_word <= 1'b0;
      end else begin
         // request drops in the cycle the last ack is taken
         rdma_req  <= rdma_busy && !(rdma_req && rdma_ack && rcnt == rstep);
         rdma_addr <= (rdma_req && rdma_ack) ? raddr + rstep : raddr;
         rdma_word <= word_mode && ((rdma_req && rdma_ack) ?
                      rcnt - rstep > 16'h0001 : rcnt > 16'h0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit: preamble, delimiter, programmed bytes, fcs
   logic [1:0]  tx_div;
   logic [5:0]  tx_bitn;
   logic [15:0] tx_left;
   logic [7:0]  tx_shift;
   logic [7:0]  tx_buf;
   logic [31:0] tx_crc;
   logic        re_d;

   wire tx_tick  = tx_div == 2'(BIT_CYC - 1);
   wire tx_load  = tx_tick && ((tx_st == T_PRE && tx_bitn == PRE_LAST) ||
                   (tx_st == T_DATA && tx_bitn[2:0] == 3'h7 &&
                    tx_left != 16'h0000));
   wire tx_start = tx_go && tx_st == T_IDLE && tx_length != 16'h0000;
   wire tx_fetch = tx_start || (tx_load && tx_left > 16'h0001);
   // preamble alternates 1,0 and the last two bits form the delimiter
   wire pre_bit  = (tx_bitn >= PRE_ALT_BITS) | ~tx_bitn[0];

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st   <= T_IDLE;
         tx_div  <= 2'h0;
         tx_bitn <= 6'h00;
         tx_left <= 16'h0000;
         tx_addr <= 16'h0000;
         tx_crc  <= CRC_INIT;
      end else begin
         tx_div <= (tx_st == T_IDLE || tx_tick) ? 2'h0 : tx_div + 2'h1;
         if (tx_fetch)
            tx_addr <= tx_start ? {tx_page, 8'h00} : tx_addr + 16'h0001;
         unique case (tx_st)
            T_IDLE: if (tx_start) begin
               tx_st   <= T_PRE;
               tx_bitn <= 6'h00;
               tx_left <= tx_length;
               tx_crc  <= CRC_INIT;
            end
            T_PRE: if (tx_tick) begin
               tx_bitn <= tx_bitn + 6'h01;
               if (tx_load) begin
                  tx_st   <= T_DATA;
                  tx_left <= tx_left - 16'h0001;
               end
            end
            T_DATA: if (tx_tick) begin
               tx_crc  <= crc_step(tx_crc, tx_shift[0]);
               tx_bitn <= tx_bitn + 6'h01;
               if (tx_load)
                  tx_left <= tx_left - 16'h0001;
               else if (tx_bitn[2:0] == 3'h7) begin
                  tx_st   <= T_FCS;
                  tx_bitn <= 6'h00;
               end
            end
            T_FCS: if (tx_tick) begin
               tx_crc  <= {tx_crc[30:0], 1'b0};
               tx_bitn <= tx_bitn + 6'h01;
               if (tx_bitn == FCS_LAST)
                  tx_st <= T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_shift <= 8'h00;
         tx_buf   <= 8'h00;
         re_d     <= 1'b0;
      end else begin
         re_d <= lmem_re;
         if (re_d)
            tx_buf <= lmem_rdata;
         if (tx_load)
            tx_shift <= tx_buf;
         else if (tx_tick && tx_st == T_DATA)
            tx_shift <= {1'b0, tx_shift[7:1]};
      end
   end

   logic tx_line;
   always_comb begin
      tx_line = 1'b0;
      unique case (tx_st)
         T_IDLE: tx_line = 1'b0;
         T_PRE:  tx_line = pre_bit;
         T_DATA: tx_line = tx_shift[0];
         T_FCS:  tx_line = ~tx_crc[31];
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_bit <= 1'b0;
         tx_en  <= 1'b0;
      end else begin
         tx_bit <= tx_line;
         tx_en  <= tx_st != T_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive pins: two flops each, edge detect after the second
   logic [1:0] crs_s, bit_s, stb_s;
   logic       stb_d;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         crs_s <= 2'h0;
         bit_s <= 2'h0;
         stb_s <= 2'h0;
         stb_d <= 1'b0;
      end else begin
         crs_s <= {crs_s[0], rx_crs};
         bit_s <= {bit_s[0], rx_bit};
         stb_s <= {stb_s[0], rx_stb};
         stb_d <= stb_s[1];
      end
   end
   wire crs  = crs_s[1];
   wire rbit = bit_s[1];
   wire rstb = stb_s[1] && !stb_d;

   ////////////////////////////////////////////////////////////////////////
   // receive: align, filter, store into the page ring
   logic [7:0]  rx_sr;
   logic [2:0]  rx_bitc;
   logic [5:0]  rx_destc;
   logic [15:0] rx_len;
   logic [31:0] rx_crc;
   logic [5:0]  rx_hash;
   logic        rx_prev;
   logic        phys_ok;
   logic        first_dest_bit;
   logic        rx_accept;
   logic [1:0]  hdr_idx;

   wire [31:0] rx_crc_n  = crc_step(rx_crc, rbit);
   wire [7:0]  rx_byte   = {rbit, rx_sr[7:1]};
   wire        byte_done = rx_st == R_DATA && rstb && rx_bitc == 3'h7;
   wire        in_dest   = rx_len < 16'(DEST_BYTES);
   wire        st_match  = rx_byte == station_addr_bytes[rx_len[2:0]];
   wire        last_dest = rx_len == 16'(DEST_BYTES - 3'h1);
   // multicast bit sits in bit 0 of the first byte
   wire        mc_now    = (rx_len == 16'h0000) ? rx_byte[0] : first_dest_bit;
   wire        hash_hit  = multicast_hash_filter[rx_hash];
   // address write lands in the byte cell, then steps and may wrap the page
   wire        page_end  = rx_addr[7:0] == 8'hff;
   wire [7:0]  next_pg   = page_next(rx_addr[15:8], ring_first_page,
                                     ring_end_page);
   wire        ring_full = byte_done && page_end &&
                           next_pg == ring_read_page;
   wire        good_end  = !crs && rx_accept && !in_dest &&
                           rx_crc == CRC_RESIDUE;
   assign hdr_next_page = (rx_addr[7:0] == 8'h00) ? rx_addr[15:8] :
                          page_next(rx_addr[15:8], ring_first_page,
                                    ring_end_page);
   assign hdr_done = rx_st == R_HDR && hdr_idx == 2'h3;

   logic [7:0] hdr_byte;
   always_comb begin
      hdr_byte = 8'h00;
      unique case (hdr_idx)
         2'h0: hdr_byte = first_dest_bit ? RX_STAT_MC | RX_STAT_OK
                                         : RX_STAT_OK;
         2'h1: hdr_byte = hdr_next_page;
         2'h2: hdr_byte = rx_len[7:0];
         2'h3: hdr_byte = rx_len[15:8];
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st <= R_IDLE;
         rx_addr <= 16'h0000;
         rx_sr <= 8'h00;
         rx_bitc <= 3'h0;
         rx_destc <= 6'h00;
         rx_len <= 16'h0000;
         rx_crc <= CRC_INIT;
         rx_hash <= 6'h00;
         rx_prev <= 1'b0;
         phys_ok <= 1'b0;
         first_dest_bit <= 1'b0;
         rx_accept <= 1'b0;
         hdr_idx <= 2'h0;
      end else begin
         unique case (rx_st)
            R_IDLE: if (crs && rx_enable && tx_st == T_IDLE) begin
               rx_st   <= R_HUNT;
               rx_prev <= 1'b0;
            end
            R_HUNT: if (!crs)
               rx_st <= R_IDLE;
            else if (rstb) begin
               rx_prev <= rbit;
               if (rbit && rx_prev) begin
                  rx_st    <= R_DATA;
                  rx_addr  <= {ring_write_page, STATUS_SKIP};
                  rx_bitc  <= 3'h0;
                  rx_destc <= 6'h00;
                  rx_len   <= 16'h0000;
                  rx_crc   <= CRC_INIT;
                  phys_ok  <= 1'b1;
               end
            end
            R_DATA: if (!crs) begin
               // frame ends: keep only clean, accepted frames
               rx_st   <= good_end ? R_HDR : R_DROP;
               hdr_idx <= 2'h0;
               if (!good_end)
                  rx_addr <= {ring_write_page, 8'h00};
            end else if (rstb) begin
               rx_sr   <= rx_byte;
               rx_bitc <= rx_bitc + 3'h1;
               rx_crc  <= rx_crc_n;
               if (in_dest)
                  rx_destc <= rx_destc + 6'h01;
               if (in_dest && rx_destc == DEST_LAST)
                  rx_hash <= rx_crc_n[31:26];
               if (byte_done) begin
                  rx_len  <= rx_len + 16'h0001;
                  rx_addr <= page_end ? {next_pg, 8'h00}
                                      : rx_addr + 16'h0001;
                  if (rx_len == 16'h0000)
                     first_dest_bit <= rx_byte[0];
                  if (in_dest)
                     phys_ok <= phys_ok && st_match;
                  if (last_dest)
                     rx_accept <= mc_now ? 1'b0 : phys_ok && st_match;
                  if (ring_full) begin
                     rx_st   <= R_DROP;
                     rx_addr <= {ring_write_page, 8'h00};
                  end
               end
               if (rx_len == 16'(DEST_BYTES) && rx_bitc == 3'h0 &&
                   first_dest_bit)
                  rx_accept <= hash_hit;
            end
            R_HDR: begin
               hdr_idx <= hdr_idx + 2'h1;
               if (hdr_done) begin
                  rx_st   <= R_DROP;
                  rx_addr <= {hdr_next_page, 8'h00};
               end
            end
            R_DROP: if (!crs)
               rx_st <= R_IDLE;
            default: rx_st <= R_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // local memory port, registered
   wire rx_accept_or_dest = in_dest || rx_accept || first_dest_bit;
   wire rx_we = byte_done && rx_accept_or_dest;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lmem_addr  <= 16'h0000;
         lmem_wdata <= 8'h00;
         lmem_we    <= 1'b0;
         lmem_re    <= 1'b0;
      end else begin
         lmem_re <= tx_fetch;
         lmem_we <= rx_we || rx_st == R_HDR;
         if (tx_fetch)
            lmem_addr <= tx_start ? {tx_page, 8'h00} : tx_addr + 16'h0001;
         else if (rx_st == R_HDR)
            lmem_addr <= {ring_write_page, 6'h00, hdr_idx};
         else
            lmem_addr <= rx_addr;
         lmem_wdata <= (rx_st == R_HDR) ? hdr_byte : rx_byte;
      end
   end

endmodule // nicdf_top

`default_nettype wire

// ### nicdf_top_assertions.sv
// port-level properties of the nic dma, filter and framing top
`timescale 1ns/10ps
`default_nettype none
module nicdf_top_chk import nicdf_pkg::*; (
   // clock, reset and register port
   input wire logic clock, sys_rst, reg_wr, reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   // memory, remote steps and serial side
   input wire logic [15:0] lmem_addr, rdma_addr,
   input wire logic lmem_re, rdma_req, rdma_ack, rdma_word, tx_bit, tx_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata");
   property p_hold; rdma_req && !rdma_ack |=> rdma_req && $stable(rdma_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("req hold");
   property p_step; rdma_req && rdma_ack |=> !rdma_req ||
      rdma_addr == $past(rdma_addr) + ($past(rdma_word) ? 16'h2 : 16'h1);
   endproperty
   a_step: assert property (p_step) else $error("step");
   property p_go; $rose(rdma_req) |-> $past(reg_wr, 2) &&
      $past(reg_addr, 2) == REG_CTRL; endproperty
   a_go: assert property (p_go) else $error("go");
   property p_end; $fell(rdma_req) |-> $past(rdma_ack); endproperty
   a_end: assert property (p_end) else $error("end");
   property p_pre; $rose(tx_en) |-> tx_bit [*4] ##1 !tx_bit [*4] ##1 tx_bit;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble");
   property p_sfd; $rose(tx_en) |-> ##244 !tx_bit [*4] ##1 tx_bit [*8];
   endproperty
   a_sfd: assert property (p_sfd) else $error("delimiter");
   property p_fetch; $rose(tx_en) |-> $past(lmem_re) &&
      ($past(lmem_addr) & 16'h00ff) == 16'h0000; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch");
endmodule // nicdf_top_chk
bind nicdf_top nicdf_top_chk u_chk (.clock(clock), .sys_rst(sys_rst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .lmem_addr(lmem_addr), .rdma_addr(rdma_addr),
   .lmem_re(lmem_re), .rdma_req(rdma_req), .rdma_ack(rdma_ack),
   .rdma_word(rdma_word), .tx_bit(tx_bit), .tx_en(tx_en));
`default_nettype wire

// ### nicdf_mem_model.sv
// buffer memory and remote step acknowledger
`timescale 1ns/10ps
`default_nettype none
module nicdf_mem_model (
   input wire logic clock, lmem_re, rdma_req,
   input wire logic [15:0] lmem_addr,
   output var logic [7:0] lmem_rdata,
   output var logic rdma_ack
);
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'ha5;
      lmem_rdata = 8'h00;
      rdma_ack = 1'b0;
   end
   // data only valid after a read; otherwise it keeps changing
   always @(posedge clock) begin
      lmem_rdata <= lmem_re ? mem[lmem_addr] : ~lmem_rdata;
      rdma_ack <= rdma_req && !rdma_ack;
   end
endmodule // nicdf_mem_model
`default_nettype wire

// ### nicdf_top_tb_top.sv
// self-checking bench for the nic dma, filter and framing top
`timescale 1ns/10ps
`default_nettype none
module nicdf_top_tb_top;
   import nicdf_pkg::*;
   logic clock, sys_rst, reg_wr, reg_rd, rdma_ack, lmem_we, lmem_re;
   logic rdma_req, rdma_word, tx_bit, tx_en;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lmem_wdata, lmem_rdata, e, v;
   logic [31:0] c;
   logic rx_crs, rx_bit, rx_stb;
   logic [15:0] lmem_addr, rdma_addr;
   logic [111:0] txs;
   logic [16:0] steps [$];
   logic [23:0] wrs [$];
   int errors = 0, checks = 0, txlen = 0;
   nicdf_top dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .lmem_addr(lmem_addr), .lmem_wdata(lmem_wdata),
      .lmem_we(lmem_we), .lmem_re(lmem_re), .lmem_rdata(lmem_rdata),
      .rdma_req(rdma_req), .rdma_addr(rdma_addr), .rdma_word(rdma_word),
      .rdma_ack(rdma_ack), .tx_bit(tx_bit), .tx_en(tx_en),
      .rx_crs(rx_crs), .rx_bit(rx_bit), .rx_stb(rx_stb));
   nicdf_mem_model mem (.clock(clock), .lmem_re(lmem_re),
      .rdma_req(rdma_req), .lmem_addr(lmem_addr),
      .lmem_rdata(lmem_rdata), .rdma_ack(rdma_ack));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (rdma_req && rdma_ack) steps.push_back({rdma_word, rdma_addr});
      if (lmem_we) wrs.push_back({lmem_addr, lmem_wdata});
      if (tx_en && txlen % 4 == 1) txs = {tx_bit, txs[111:1]};
      if (tx_en) txlen++;
   end
   task automatic chk(string n, logic [79:0] x, logic [79:0] g);
      checks++;
      if (g !== x) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   // one access, then a gap cycle so strobes never toggle twice at once
   task automatic acc(logic w, logic [4:0] a, logic [7:0] d, logic [7:0] x);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clock);
      if (!w) chk($sformatf("reg %h", a), x, reg_rdata);
   endtask
   // serial bits lsb first, strobe holds each level for two clocks
   task automatic rxb(logic [7:0] b, int n);
      for (int j = 0; j < n; j++) begin
         {rx_bit, rx_stb} <= {b[j], 1'b0};
         repeat (2) @(posedge clock);
         rx_stb <= 1'b1;
         repeat (2) @(posedge clock);
      end
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clock);
      errors++;
      conclude;
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h8000;
      {rx_crs, rx_bit, rx_stb} = 3'h0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      // write page starts at the first page; filter all ones takes any group
      for (int i = 0; i < 32; i++) begin
         v = (i == 6) ? 8'h43 : (i > 23) ? 8'hff : 8'(8'h40 + i);
         if (i != 15) acc(1, 5'(i), v, 0);
      end
      for (int i = 0; i < 32; i++) begin
         v = (i == 6) ? 8'h43 : (i > 23) ? 8'hff : 8'(8'h40 + i);
         e = (i < 7 || (i > 8 && i < 13) || (i > 15 && i != 22 && i != 23))
            ? v : 8'h00;
         if (i != 15) acc(0, 5'(i), 0, e);
      end
      acc(1, REG_RSTART_LO, 8'hfe, 0);
      acc(1, REG_RSTART_HI, 8'h12, 0);
      acc(1, REG_RCOUNT_LO, 8'h05, 0);
      acc(1, REG_RCOUNT_HI, 8'h00, 0);
      acc(1, REG_CTRL, 8'h06, 0);
      for (int k = 0; k < 60 && (rdma_req || k < 4); k++) @(posedge clock);
      chk("steps", 3, steps.size());
      chk("s0", 17'h112fe, steps[0]);
      chk("s1", 17'h11300, steps[1]);
      chk("s2", 17'h01302, steps[2]);
      acc(0, REG_RADDR_LO, 0, 8'h03);
      acc(0, REG_RADDR_HI, 0, 8'h13);
      acc(0, REG_CTRL, 0, 8'h04);
      acc(1, REG_TX_PAGE, 8'h20, 0);
      acc(1, REG_TX_LEN_LO, 8'h02, 0);
      acc(1, REG_TX_LEN_HI, 8'h00, 0);
      acc(1, REG_CTRL, 8'h01, 0);
      for (int k = 0; k < 600 && (tx_en || k < 4); k++) @(posedge clock);
      chk("tx cycles", 448, txlen);
      chk("preamble", 64'hd555555555555555, txs[63:0]);
      chk("tx data", 16'ha4a5, txs[79:64]);
      c = CRC_INIT;
      for (int i = 64; i < 112; i++)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ txs[i]) ? CRC_POLY : 32'h0);
      chk("fcs residue", CRC_RESIDUE, c);
      // own station frame with a bad crc: stored, then dropped
      acc(1, REG_CTRL, 8'h08, 0);
      rx_crs <= 1'b1;
      rxb(8'h35, 6);
      for (int k = 0; k < 8; k++) rxb(8'(8'h50 + k), 8);
      rx_crs <= 1'b0;
      repeat (8) @(posedge clock);
      chk("rx writes", 8, wrs.size());
      for (int k = 0; k < 8; k++)
         chk("rx wr", {16'h4304 + 16'(k), 8'(8'h50 + k)}, wrs[k]);
      acc(0, REG_LDA_LO, 0, 8'h00);
      acc(0, REG_RING_WRITE, 0, 8'h43);
      conclude;
   end
endmodule // nicdf_top_tb_top
`default_nettype wire
